// >>> tmo_load.sv
// load model counting the cycles it is energised
`timescale 1ns/10ps
module tmo_load
(
   input  wire logic        clk_sys,
   input  wire logic        ctrl_out,
   input  wire logic        clr,
   output logic      [15:0] on_cyc
);
   always_ff @(posedge clk_sys)
   begin
      if (clr)
         on_cyc <= 16'h0000;
      else if (ctrl_out)
         on_cyc <= on_cyc + 16'h0001;
   end
endmodule

// >>> tmo_map.svh
// constants for the timer output mode logic
`ifndef TMO_MAP_SVH
`define TMO_MAP_SVH
`define TMO_CLK_HZ        10000000
`define TMO_TICK_US       1000
`define TMO_TICK_CYC      ((`TMO_CLK_HZ / 1000000) * `TMO_TICK_US)
`define TMO_CNT_W         16
`define TMO_SET_RST       16'h0000
`define TMO_MIN_SET_MS    100
`endif

// >>> tmo_pkg.sv
// types for the timer output mode logic
package tmo_pkg;
   typedef enum logic [1:0] {TMO_ON_DELAY, TMO_OFF_DELAY, TMO_INTERVAL} tmo_mode_e;
   typedef enum logic [1:0] {TMO_IDLE, TMO_TIMING, TMO_DONE} tmo_state_e;
endpackage

// >>> tmo_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module tmo_sync
(
   input  wire logic clk_sys,
   input  wire logic rstn,
   input  wire logic d_in,
   output logic      q_out
);
   logic meta_reg;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_reg <= 1'b0;
         q_out    <= 1'b0;
      end
      else
      begin
         meta_reg <= d_in;
         q_out    <= meta_reg;
      end
   end
endmodule

// >>> tmo_tick_if.sv
// carrier between the time base and the mode logic
`timescale 1ns/10ps
interface tmo_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface

// >>> tmo_time_base.sv
// internal time base producing one-cycle tick enables
`timescale 1ns/10ps
`include "tmo_map.svh"
module tmo_time_base
#(
   parameter int TICK_CYC = `TMO_TICK_CYC
)
(
   input  wire logic clk_sys,
   input  wire logic rstn,
   tmo_tick_if.src   tb
);
   logic [31:0] div_reg;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         div_reg <= 32'h0000_0000;
         tb.tick <= 1'b0;
      end
      else if (div_reg >= 32'(TICK_CYC - 1))
      begin
         div_reg <= 32'h0000_0000;
         tb.tick <= 1'b1;
      end
      else
      begin
         div_reg <= div_reg + 32'h0000_0001;
         tb.tick <= 1'b0;
      end
   end
endmodule

// >>> tmo_timer.sv
// timer output mode logic: on-delay, signal off-delay and interval modes
// Behaviour
// - in on-delay mode start changes are ignored while timing runs.
// - in on-delay mode timing begins on the rising edge of start.
// - in on-delay mode the output comes on at time-up and stays on until reset.
// - in on-delay and interval modes a start already on at power-up or at reset release begins timing at once.
// - in off-delay mode the output is on while start is on, unless reset is active.
// - in off-delay mode time-up clears timing and turns the output off.
// - in off-delay mode with set time zero the output follows start alone.
// - in off-delay mode start stays live while timing and restarts the delay.
// - in off-delay mode power-up discards elapsed time and returns to idle.
// - in interval mode power-up discards time and start on begins a new measurement.
// - in interval mode the output goes off when elapsed time reaches set time.
// - in interval mode power-up resets timing instead of resuming a count.
`timescale 1ns/10ps
`include "tmo_map.svh"
module tmo_timer
import tmo_pkg::*;
#(
   parameter int CNT_W    = `TMO_CNT_W,
   parameter int TICK_CYC = `TMO_TICK_CYC
)
(
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   input  wire logic             start_pin,
   input  wire logic             reset_pin,
   input  wire tmo_mode_e        mode,
   input  wire logic             count_down,
   input  wire logic [CNT_W-1:0] set_value,
   output logic                  ctrl_out,
   output logic                  timing,
   output logic [CNT_W-1:0]      present_value
);
   tmo_tick_if tb_if ();
   logic             start_s;
   logic             reset_s;
   logic             start_d_reg;
   logic             first_reg;
   tmo_state_e       state_reg;
   logic [CNT_W-1:0] elapsed_reg;
   logic             start_rise;
   logic             time_up;
   logic             out_next;

   tmo_time_base #(.TICK_CYC(TICK_CYC)) u_tb
   (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .tb      (tb_if.src)
   );

   tmo_sync u_sync_start
   (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .d_in    (start_pin),
      .q_out   (start_s)
   );

   tmo_sync u_sync_reset
   (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .d_in    (reset_pin),
      .q_out   (reset_s)
   );

   // elapsed count shown in the chosen direction
   function automatic logic [CNT_W-1:0] shown(input logic dn, input logic [CNT_W-1:0] e,
                                             input logic [CNT_W-1:0] s);
      shown = dn ? (s - e) : e;
   endfunction

   // first cycle after power-up: first_reg holds start_rise off, so no edge counts in that cycle
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         first_reg <= 1'b1;
      else
         first_reg <= 1'b0;
   end

   // previous start level; forced low during reset so release with start on acts as an edge
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         start_d_reg <= 1'b0;
      else if (reset_s)
         start_d_reg <= 1'b0;
      else
         start_d_reg <= start_s;
   end

   assign start_rise = start_s && !start_d_reg && !first_reg;
   assign time_up    = (elapsed_reg >= set_value);

   // timing state and elapsed count
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg   <= TMO_IDLE;
         elapsed_reg <= '0;
      end
      else if (reset_s)
      begin
         state_reg   <= TMO_IDLE;
         elapsed_reg <= '0;
      end
      else
      begin
         case (state_reg)
            TMO_IDLE:
            begin
               elapsed_reg <= '0;
               if (mode == TMO_OFF_DELAY)
               begin
                  if (!start_s && start_d_reg && set_value != '0)
                     state_reg <= TMO_TIMING;
               end
               else if (start_rise)
               begin
                  state_reg <= (set_value == '0) ? TMO_DONE : TMO_TIMING;
               end
            end
            TMO_TIMING:
            begin
               if (mode == TMO_OFF_DELAY && start_s)
               begin
                  state_reg   <= TMO_IDLE;
                  elapsed_reg <= '0;
               end
               else if (tb_if.tick)
               begin
                  if (elapsed_reg + 1'b1 >= set_value)
                  begin
                     elapsed_reg <= set_value;
                     state_reg   <= (mode == TMO_OFF_DELAY) ? TMO_IDLE : TMO_DONE;
                  end
                  else
                     elapsed_reg <= elapsed_reg + 1'b1;
               end
            end
            TMO_DONE:
            begin
               if (mode == TMO_INTERVAL && start_rise)
               begin
                  state_reg   <= (set_value == '0) ? TMO_DONE : TMO_TIMING;
                  elapsed_reg <= '0;
               end
            end
            default:
               state_reg <= TMO_IDLE;
         endcase
      end
   end

   // output per mode
   always_comb
   begin
      out_next = 1'b0;
      case (mode)
         TMO_ON_DELAY:
            out_next = (state_reg == TMO_DONE);
         TMO_OFF_DELAY:
            out_next = start_s || (state_reg == TMO_TIMING) ||
                       (state_reg == TMO_IDLE && start_d_reg && set_value != '0);
         TMO_INTERVAL:
            out_next = (state_reg == TMO_TIMING) && !time_up;
         default:
            out_next = 1'b0;
      endcase
      if (reset_s)
         out_next = 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         ctrl_out      <= 1'b0;
         timing        <= 1'b0;
         present_value <= `TMO_SET_RST;
      end
      else
      begin
         ctrl_out      <= out_next;
         timing        <= (state_reg == TMO_TIMING);
         present_value <= shown(count_down, elapsed_reg, set_value);
      end
   end
endmodule

// >>> tmo_timer_props.sv
// checker for the timer output mode logic
`timescale 1ns/10ps
module tmo_timer_props
import tmo_pkg::*;
#(
   parameter int CNT_W = 16
)
(
   input wire logic             clk_sys,
   input wire logic             rstn,
   input wire logic             start_pin,
   input wire logic             reset_pin,
   input wire tmo_mode_e        mode,
   input wire logic             count_down,
   input wire logic [CNT_W-1:0] set_value,
   input wire logic             ctrl_out,
   input wire logic             timing,
   input wire logic [CNT_W-1:0] present_value
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   AST_RST_CLEAR: assert property (
      reset_pin[*5] |=> !ctrl_out && !timing &&
      present_value == (count_down ? set_value : '0)) else $error("no clear");
   AST_OFFD_FOLLOW: assert property (
      (mode == TMO_OFF_DELAY && start_pin && !reset_pin)[*5] |=> ctrl_out) else $error("off");
   AST_OFFD_ZERO: assert property (
      (mode == TMO_OFF_DELAY && set_value == '0 && !start_pin)[*5] |=> !ctrl_out)
      else $error("zero set");
   AST_ON_HOLD: assert property (
      (!reset_pin)[*5] ##0 (mode == TMO_ON_DELAY && ctrl_out) |=> ctrl_out) else $error("hold");
   AST_ON_DONE: assert property (
      (!reset_pin)[*5] ##0 (mode == TMO_ON_DELAY && $fell(timing)) |-> ##[0:1] ctrl_out)
      else $error("on end");
   AST_INT_END: assert property (
      (!reset_pin)[*5] ##0 (mode == TMO_INTERVAL && $fell(timing)) |-> ##[0:2] !ctrl_out)
      else $error("int end");
   AST_INT_ON: assert property (
      mode == TMO_INTERVAL && $rose(timing) |-> ##[0:1] ctrl_out) else $error("int on");
   AST_PWR_CLEAR: assert property (
      $rose(rstn) |-> !ctrl_out && !timing && present_value == '0) else $error("pwr");
   cover property (mode == TMO_ON_DELAY && $rose(ctrl_out));
   cover property (mode == TMO_OFF_DELAY && $fell(ctrl_out) && !start_pin);
   cover property (mode == TMO_INTERVAL && count_down && $fell(timing));
endmodule
bind tmo_timer tmo_timer_props #(.CNT_W(CNT_W)) i_tmo_timer_props (.clk_sys, .rstn,
   .start_pin, .reset_pin, .mode, .count_down, .set_value, .ctrl_out, .timing, .present_value);

// >>> tmo_timer_test.sv
// testbench for the timer output mode logic
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] %0t mismatch", $time); end end
module tmo_timer_test
import tmo_pkg::*;
;
   logic        clk_sys, rstn, start_pin, reset_pin, count_down, ctrl_out, timing, clr;
   tmo_mode_e   mode;
   logic [15:0] set_value, present_value, on_cyc;
   int          err_count, checks_done;
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   tmo_timer #(.CNT_W(16), .TICK_CYC(4)) i_tmo_timer (.clk_sys, .rstn, .start_pin,
      .reset_pin, .mode, .count_down, .set_value, .ctrl_out, .timing, .present_value);
   tmo_load i_tmo_load (.clk_sys, .ctrl_out, .clr, .on_cyc);
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task final_report;
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task wait_out(input logic v);
      for (int i = 0; i < 80 && ctrl_out !== v; i++) @(posedge clk_sys);
      if (ctrl_out !== v)
      begin
         `CHK(ctrl_out, v)
         final_report();
      end
   endtask
   task t_on_delay;
      mode <= TMO_ON_DELAY;
      set_value <= 16'h0002;
      start_pin <= 1'b1;
      cyc(5);
      `CHK(timing, 1'b1)
      start_pin <= 1'b0;
      cyc(2);
      start_pin <= 1'b1;
      wait_out(1'b1);
      start_pin <= 1'b0;
      cyc(20);
      `CHK(ctrl_out, 1'b1)
      reset_pin <= 1'b1;
      cyc(6);
      `CHK({ctrl_out, timing, present_value}, 18'h00000)
      reset_pin <= 1'b0;
   endtask
   task t_off_delay(input logic [15:0] sv);
      mode <= TMO_OFF_DELAY;
      set_value <= sv;
      start_pin <= 1'b1;
      cyc(6);
      `CHK(ctrl_out, 1'b1)
      start_pin <= 1'b0;
      cyc(6);
      `CHK(ctrl_out, sv != 16'h0000)
      start_pin <= 1'b1;
      cyc(2);
      start_pin <= 1'b0;
      cyc(9);
      `CHK(ctrl_out, sv != 16'h0000)
      wait_out(1'b0);
      `CHK(timing, 1'b0)
   endtask
   task t_interval;
      mode <= TMO_INTERVAL;
      set_value <= 16'h0003;
      count_down <= 1'b1;
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      start_pin <= 1'b1;
      wait_out(1'b1);
      cyc(2);
      `CHK(present_value <= 16'h0003, 1'b1)
      wait_out(1'b0);
      `CHK(on_cyc >= 16'h0008 && on_cyc <= 16'h000e, 1'b1)
      cyc(10);
      `CHK(ctrl_out, 1'b0)
      rstn <= 1'b0;
      cyc(2);
      `CHK({ctrl_out, timing, present_value}, 18'h00000)
      mode <= TMO_ON_DELAY;
      rstn <= 1'b1;
      cyc(7);
      `CHK(timing, 1'b1)
      reset_pin <= 1'b1;
      cyc(6);
      reset_pin <= 1'b0;
      cyc(7);
      `CHK(timing, 1'b1)
   endtask
   initial
   begin
      rstn = 1'b0;
      start_pin = 1'b0;
      reset_pin = 1'b0;
      count_down = 1'b0;
      clr = 1'b0;
      mode = TMO_ON_DELAY;
      set_value = 16'h0000;
      cyc(12);
      rstn <= 1'b1;
      cyc(2);
      t_on_delay();
      t_off_delay(16'h0003);
      t_off_delay(16'h0000);
      t_interval();
      final_report();
   end
endmodule
